//--- hw/odtp_pkg.sv
// Package for the power-down termination mode transition block.
// Assumes a 200 MHz core clock; memory clock times are counted in core cycles.
package odtp_pkg;

    // ==========================================
    // Clock
    localparam int  CLK_PERIOD_PS   = 5000;

    // ==========================================
    // Asynchronous termination delays
    localparam int  T_AONPD_MIN_PS  = 2000;
    localparam int  T_AONPD_MAX_PS  = 8500;
    localparam int  T_AOFPD_MIN_PS  = 2000;
    localparam int  T_AOFPD_MAX_PS  = 8500;
    // Least time rounds up, longest rounds down, never below one cycle
    localparam int  AONPD_MIN_CYC   = (T_AONPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int  AONPD_MAX_CYC   = (T_AONPD_MAX_PS / CLK_PERIOD_PS) < 1 ? 1 :
                                      (T_AONPD_MAX_PS / CLK_PERIOD_PS);
    localparam int  AOFPD_MIN_CYC   = (T_AOFPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int  AOFPD_MAX_CYC   = (T_AOFPD_MAX_PS / CLK_PERIOD_PS) < 1 ? 1 :
                                      (T_AOFPD_MAX_PS / CLK_PERIOD_PS);

    // ==========================================
    // Latency arithmetic
    localparam int  ODTL_OFFSET     = 2;
    localparam int  ANPD_OFFSET     = 1;
    localparam int  DLL_OFF_BIT     = 12;
    localparam bit  DLL_OFF_VALUE   = 1'b0;

    // ==========================================
    // Counter widths and defaults
    localparam int  LAT_W           = 6;
    localparam int  CNT_W           = 10;
    localparam logic [CNT_W-1:0] XPDLL_DEF = 10'h00a;
    localparam logic [CNT_W-1:0] RFC_DEF   = 10'h020;

    // Termination response mode
    typedef enum logic [1:0] {
        ODTP_SYNC,
        ODTP_ASYNC,
        ODTP_EITHER
    } odtp_mode_e;

endpackage

//--- hw/odtp_delay.sv
// Programmable delay line for the termination request.
// Assumes the request is already synchronised to ref_clk_in.
`timescale 1ns/1ps
module odtp_delay #(
    parameter int DEPTH = 64
) (
    // Clock and reset
    input  wire logic                     ref_clk_in,
    input  wire logic                     rst_b_in,
    // Request and delay
    input  wire logic                     req_in,
    input  wire logic [$clog2(DEPTH)-1:0] tap_in,
    output logic                          dly_out
);
    logic [DEPTH-1:0] line_q;
    logic [DEPTH-1:0] line_d;

    // ==========================================
    // Shift line
    always_comb begin
        line_d = {line_q[DEPTH-2:0], req_in};
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            line_q <= '0;
        end else begin
            line_q <= line_d;
        end
    end

    // Tap zero gives one cycle; registered path keeps output glitch free
    assign dly_out = line_q[tap_in];
endmodule

//--- hw/odtp_top.sv
// Termination response mode tracker around precharge power-down, DLL off.
// Assumes CKE, ODT and refresh strobe come from pins; configuration is static.
//
// Behaviour
// RQ1: Turn-on between min and max bound
// RQ2: Turn-off between min and max bound
// RQ3: Anticipation interval equals write latency minus one
// RQ4: Exit window spans anticipation plus exit delay
// RQ5: Windows only when DLL-off bit is zero
// RQ6: Exit window response may be either
// RQ7: Write latency is CAS write plus additive
// RQ8: Short low pulse: either until exit end
// RQ9: Short high pulse: either until entry end
// RQ10: Synchronous after exit, asynchronous before it
// RQ11: Entry window ends at CKE low or refresh
// RQ12: Async path ignores additive latency, sampled edges
// RQ13: Controller treats termination unknown inside windows
`timescale 1ns/1ps
module odtp_top
    import odtp_pkg::*;
#(
    parameter logic [odtp_pkg::CNT_W-1:0] XPDLL_CYC = odtp_pkg::XPDLL_DEF,
    parameter logic [odtp_pkg::CNT_W-1:0] RFC_CYC   = odtp_pkg::RFC_DEF,
    parameter int                         DLY_DEPTH = 64
) (
    // Clock and reset
    input  wire logic                        ref_clk_in,
    input  wire logic                        rst_b_in,
    // Pins from the controller
    input  wire logic                        cke_in,
    input  wire logic                        odt_in,
    input  wire logic                        refresh_in,
    // Static configuration
    input  wire logic                        mr0_bit12_in,
    input  wire logic [odtp_pkg::LAT_W-1:0]  cwl_in,
    input  wire logic [odtp_pkg::LAT_W-1:0]  al_in,
    // Status
    output logic                             rtt_on_out,
    output logic                             power_down_out,
    output logic                             entry_window_out,
    output logic                             exit_window_out,
    output logic [1:0]                       mode_out
);
    import odtp_pkg::*;

    localparam int TW = $clog2(DLY_DEPTH);

    // ==========================================
    // Pin synchronisers
    logic [1:0] cke_s_q, odt_s_q, ref_s_q;
    logic [1:0] cke_s_d, odt_s_d, ref_s_d;
    logic       cke, odt, ref_req;

    always_comb begin
        cke_s_d = {cke_s_q[0], cke_in};
        odt_s_d = {odt_s_q[0], odt_in};
        ref_s_d = {ref_s_q[0], refresh_in};
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            // CKE idles high; a low reset value would fake a rising edge
            cke_s_q <= 2'h3;
            odt_s_q <= 2'h0;
            ref_s_q <= 2'h0;
        end else begin
            cke_s_q <= cke_s_d;
            odt_s_q <= odt_s_d;
            ref_s_q <= ref_s_d;
        end
    end

    assign cke     = cke_s_q[1];
    assign odt     = odt_s_q[1];
    assign ref_req = ref_s_q[1];

    // ==========================================
    // Latency arithmetic
    logic [LAT_W-1:0] wl, odtl, anpd;
    logic             dll_off;

    assign wl      = LAT_W'(cwl_in + al_in);                   // RQ7
    assign odtl    = (wl > LAT_W'(ODTL_OFFSET)) ? LAT_W'(wl - LAT_W'(ODTL_OFFSET))
                                                 : '0;
    assign anpd    = LAT_W'(odtl + LAT_W'(ANPD_OFFSET));       // RQ3
    assign dll_off = (mr0_bit12_in == DLL_OFF_VALUE);          // RQ5

    // ==========================================
    // CKE edge tracking and windows
    // The anticipation part of each window lies before the CKE edge, so the
    // window is reported from that edge and the preceding anpd cycles are
    // covered by history: entry is flagged if CKE was high in the last anpd.
    logic             cke_prev_q, pd_q, entry_q, exit_q;
    logic             cke_prev_d, pd_d, entry_d, exit_d;
    logic [CNT_W-1:0] hi_cnt_q, lo_cnt_q, exit_cnt_q, rfc_cnt_q;
    logic [CNT_W-1:0] hi_cnt_d, lo_cnt_d, exit_cnt_d, rfc_cnt_d;
    logic             fall, rise;

    assign fall = cke_prev_q & ~cke;
    assign rise = ~cke_prev_q & cke;

    always_comb begin
        cke_prev_d = cke;
        pd_d       = pd_q;
        entry_d    = entry_q;
        exit_d     = exit_q;
        hi_cnt_d   = cke ? ((hi_cnt_q == '1) ? hi_cnt_q : CNT_W'(hi_cnt_q + 1'b1)) : '0;
        lo_cnt_d   = cke ? '0 : ((lo_cnt_q == '1) ? lo_cnt_q : CNT_W'(lo_cnt_q + 1'b1));
        exit_cnt_d = (exit_cnt_q != '0) ? CNT_W'(exit_cnt_q - 1'b1) : '0;
        rfc_cnt_d  = ref_req ? RFC_CYC
                   : ((rfc_cnt_q != '0) ? CNT_W'(rfc_cnt_q - 1'b1) : '0);
        if (fall) begin
            pd_d = 1'b1;
        end
        if (rise) begin
            pd_d = 1'b0;
        end
        // Entry lasts past CKE low while a refresh is running
        if (entry_q && rfc_cnt_q == '0 && !cke) begin                // RQ11
            entry_d = 1'b0;
        end
        if (fall && dll_off && rfc_cnt_q != '0) begin                // RQ11
            entry_d = 1'b1;
        end
        // Exit window: tXPDLL after CKE first sampled high
        if (exit_q && exit_cnt_q == '0) begin                        // RQ4
            exit_d = 1'b0;
        end
        if (rise && dll_off) begin                                   // RQ4
            exit_d     = 1'b1;
            exit_cnt_d = CNT_W'(XPDLL_CYC - 1'b1);
        end
        if (!dll_off) begin                                          // RQ5
            entry_d = 1'b0;
            exit_d  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cke_prev_q <= 1'b1;
            pd_q       <= 1'b0;
            entry_q    <= 1'b0;
            exit_q     <= 1'b0;
            hi_cnt_q   <= '1;
            lo_cnt_q   <= '0;
            exit_cnt_q <= '0;
            rfc_cnt_q  <= '0;
        end else begin
            cke_prev_q <= cke_prev_d;
            pd_q       <= pd_d;
            entry_q    <= entry_d;
            exit_q     <= exit_d;
            hi_cnt_q   <= hi_cnt_d;
            lo_cnt_q   <= lo_cnt_d;
            exit_cnt_q <= exit_cnt_d;
            rfc_cnt_q  <= rfc_cnt_d;
        end
    end

    // Anticipation: CKE moved within the last anpd cycles
    logic entry_ant, exit_ant, any_window;
    assign entry_ant  = dll_off & pd_q & (lo_cnt_q < CNT_W'(anpd));   // RQ11
    assign exit_ant   = dll_off & ~pd_q & (hi_cnt_q < CNT_W'(anpd))
                      & (hi_cnt_q != '0);                              // RQ4
    // Overlaps keep the union until the later window ends
    assign any_window = entry_q | exit_q | entry_ant | exit_ant;      // RQ8 RQ9

    // ==========================================
    // Response mode selection
    odtp_mode_e mode_q, mode_d;

    always_comb begin
        if (!dll_off) begin
            mode_d = ODTP_SYNC;
        end else if (any_window) begin
            mode_d = ODTP_EITHER;                                     // RQ6
        end else if (pd_q) begin
            mode_d = ODTP_ASYNC;                                      // RQ10
        end else begin
            mode_d = ODTP_SYNC;                                       // RQ10
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_q <= ODTP_SYNC;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ==========================================
    // Termination delay paths
    // Sync uses odtl memory clocks mapped one per core cycle; async uses
    // fixed analog bounds and ignores AL. In the either state the longer of
    // the sync tap and the async turn-on tap is used for both ODT edges.
    logic [TW-1:0] sync_tap, async_tap_on, async_tap_off, tap;
    logic          odt_dly;

    assign sync_tap      = TW'(odtl);
    assign async_tap_on  = TW'(AONPD_MAX_CYC - 1);                    // RQ12
    assign async_tap_off = TW'(AOFPD_MAX_CYC - 1);                    // RQ12

    always_comb begin
        unique case (mode_q)
            ODTP_SYNC: begin
                tap = sync_tap;
            end
            ODTP_ASYNC: begin
                tap = odt ? async_tap_on : async_tap_off;
            end
            default: begin
                // Choose the later of sync and async turn-on taps so both RQ1 and RQ2 limits hold
                tap = (sync_tap > async_tap_on) ? sync_tap : async_tap_on; // RQ1 RQ2
            end
        endcase
    end

    odtp_delay #(
        .DEPTH      (DLY_DEPTH)
    ) u_delay (
        .ref_clk_in (ref_clk_in),
        .rst_b_in   (rst_b_in),
        .req_in     (odt),
        .tap_in     (tap),
        .dly_out    (odt_dly)
    );

    logic rtt_q, rtt_d;
    always_comb begin
        rtt_d = odt_dly;                                              // RQ1 RQ2
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rtt_q <= 1'b0;
        end else begin
            rtt_q <= rtt_d;
        end
    end

    // ==========================================
    // Outputs
    assign rtt_on_out       = rtt_q;
    assign power_down_out   = pd_q;
    assign entry_window_out = entry_q | entry_ant;
    assign exit_window_out  = exit_q | exit_ant;
    assign mode_out         = mode_q;
endmodule

//--- bench/odtp_ctrl_model.sv
// Controller model driving CKE, ODT and the refresh strobe.
// Assumes bench requests change just after a rising edge.
`timescale 1ns/1ps
module odtp_ctrl_model (
    // Clock and requests
    input  wire logic ref_clk_in,
    input  wire logic pd_req_in,
    input  wire logic odt_req_in,
    input  wire logic ref_req_in,
    input  wire logic busy_in,
    // Pins
    output logic      cke_out,
    output logic      odt_out,
    output logic      refresh_out
);
    initial begin
        cke_out = 1'b1;
        odt_out = 1'b0;
        refresh_out = 1'b0;
    end
    // Requests sampled on the edge, pins moved just after it
    always @(posedge ref_clk_in) begin
        cke_out <= #1 !pd_req_in;
        refresh_out <= #1 ref_req_in;
        // State unknown in a window, so ODT moves only outside one
        if (!busy_in) odt_out <= #1 odt_req_in;
    end
endmodule

//--- bench/odtp_top_assertions.sv
// Checker for the termination mode tracker.
// Assumes it is bound to odtp_top.
`timescale 1ns/1ps
module odtp_chk
    import odtp_pkg::*;
#(
    parameter logic [odtp_pkg::CNT_W-1:0] XPDLL_CYC = odtp_pkg::XPDLL_DEF
) (
    // Clock, reset, inputs
    input wire logic       ref_clk_in,
    input wire logic       rst_b_in,
    input wire logic       odt_in,
    input wire logic       mr0_bit12_in,
    // Outputs
    input wire logic       rtt_on_out,
    input wire logic       power_down_out,
    input wire logic       entry_window_out,
    input wire logic       exit_window_out,
    input wire logic [1:0] mode_out
);
    // ==========================================
    // Helpers
    logic [CNT_W-1:0] ew_q;
    logic             quiet;
    logic             asl;
    assign quiet = !power_down_out && !entry_window_out && !exit_window_out;
    assign asl = power_down_out && !entry_window_out && !exit_window_out && !mr0_bit12_in;
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            ew_q <= '0;
        else
            ew_q <= exit_window_out ? ew_q + 1'b1 : '0;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    // ==========================================
    // Properties
    property p_dll_on_nowin;
        mr0_bit12_in |-> !entry_window_out && !exit_window_out;
    endproperty
    a_dll_on_nowin: assert property (p_dll_on_nowin) else $error("window with DLL on");
    property p_dll_on_sync;
        mr0_bit12_in |-> mode_out == ODTP_SYNC;
    endproperty
    a_dll_on_sync: assert property (p_dll_on_sync) else $error("mode not sync");
    property p_exit_either;
        exit_window_out && $past(exit_window_out) && $past(exit_window_out, 2)
            |-> mode_out == ODTP_EITHER;
    endproperty
    a_exit_either: assert property (p_exit_either) else $error("exit not either");
    property p_exit_len;
        $fell(exit_window_out) |-> ew_q == XPDLL_CYC;
    endproperty
    a_exit_len: assert property (p_exit_len) else $error("exit length wrong");
    property p_async_pd;
        asl && $past(asl) && $past(asl, 2) |-> mode_out == ODTP_ASYNC;
    endproperty
    a_async_pd: assert property (p_async_pd) else $error("power-down not async");
    property p_sync_idle;
        quiet && $past(quiet) && $past(quiet, 2) |-> mode_out == ODTP_SYNC;
    endproperty
    a_sync_idle: assert property (p_sync_idle) else $error("idle not sync");
    property p_on_early;
        $rose(odt_in) && !rtt_on_out |-> !rtt_on_out[*2];
    endproperty
    a_on_early: assert property (p_on_early) else $error("turn-on too early");
    property p_on_late;
        $rose(odt_in) ##1 odt_in[*8] |-> ##[0:16] rtt_on_out;
    endproperty
    a_on_late: assert property (p_on_late) else $error("turn-on too late");
    property p_off_late;
        $fell(odt_in) ##1 !odt_in[*8] |-> ##[0:16] !rtt_on_out;
    endproperty
    a_off_late: assert property (p_off_late) else $error("turn-off too late");
endmodule
bind odtp_top odtp_chk #(.XPDLL_CYC(XPDLL_CYC)) chk_u (.ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in), .odt_in(odt_in), .mr0_bit12_in(mr0_bit12_in),
    .rtt_on_out(rtt_on_out), .power_down_out(power_down_out),
    .entry_window_out(entry_window_out), .exit_window_out(exit_window_out),
    .mode_out(mode_out));

//--- bench/odtp_top_bench.sv
// Bench for the termination mode tracker with a controller model.
// Assumes odtp_top, the checker and the model are compiled first.
`timescale 1ns/1ps
module odtp_top_bench;
    import odtp_pkg::*;
    // ==========================================
    // Setup
    localparam logic [CNT_W-1:0] XP = 10'h006;
    localparam int               WL = 7;
    logic             clk = 1'b0;
    logic             rst_b = 1'b0;
    logic             pd_req = 1'b0;
    logic             odt_req = 1'b0;
    logic             ref_req = 1'b0;
    logic             mr0 = 1'b0;
    logic [LAT_W-1:0] cwl = 6'h05;
    logic [LAT_W-1:0] al = 6'h02;
    logic             cke, odt, refr, rtt, pd, ew_en, ew_ex;
    logic [1:0]       mode;
    int               num_errors = 0;
    int               cmp_count = 0;
    initial forever #2.5 clk = !clk;
    odtp_ctrl_model mdl_u (.ref_clk_in(clk), .pd_req_in(pd_req), .odt_req_in(odt_req),
        .ref_req_in(ref_req), .busy_in(ew_en | ew_ex), .cke_out(cke), .odt_out(odt),
        .refresh_out(refr));
    odtp_top #(.XPDLL_CYC(XP), .RFC_CYC(10'h00c)) dut_u (.ref_clk_in(clk), .rst_b_in(rst_b),
        .cke_in(cke), .odt_in(odt), .refresh_in(refr), .mr0_bit12_in(mr0), .cwl_in(cwl),
        .al_in(al), .rtt_on_out(rtt), .power_down_out(pd), .entry_window_out(ew_en),
        .exit_window_out(ew_ex), .mode_out(mode));
    // ==========================================
    // Helpers
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Edges from pin change to rtt; one edge of slack each way
    task lat(input logic v, input int e);
        int n;
        odt_req = v;
        step(1);
        n = 0;
        while (rtt !== v && n < 40) begin
            step(1);
            n++;
        end
        chk(10'(n >= e - 1 && n <= e + 1), 10'h001);
    endtask
    task close_out;
        if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task t_sync;
        chk(10'(mode), 10'(ODTP_SYNC));
        lat(1'b1, WL + 2);
        lat(1'b0, WL + 2);
    endtask
    task t_async;
        pd_req = 1'b1;
        step(12);
        chk(10'({pd, ew_en, ew_ex}), 10'h004);
        chk(10'(mode), 10'(ODTP_ASYNC));
        lat(1'b1, 4);
        lat(1'b0, 4);
    endtask
    task t_exit;
        int n;
        pd_req = 1'b0;
        n = 0;
        while (ew_ex !== 1'b1 && n < 12) begin
            step(1);
            n++;
        end
        step(2);
        chk(10'(mode), 10'(ODTP_EITHER));
        n = 2;
        while (ew_ex === 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        chk(10'(n), 10'(XP));
        step(3);
        chk(10'(mode), 10'(ODTP_SYNC));
    endtask
    task t_refresh;
        ref_req = 1'b1;
        step(1);
        ref_req = 1'b0;
        pd_req = 1'b1;
        step(8);
        chk(10'(ew_en), 10'h001);
        step(12);
        chk(10'(ew_en), 10'h000);
        t_exit;
    endtask
    task t_short;
        int n;
        logic seen;
        pd_req = 1'b1;
        step(1);
        pd_req = 1'b0;
        seen = 1'b0;
        for (n = 0; n < 30; n++) begin
            step(1);
            if (mode === ODTP_EITHER) seen = 1'b1;
        end
        chk(10'(seen), 10'h001);
    endtask
    task t_dll_on;
        rst_b = 1'b0;
        mr0 = 1'b1;
        step(2);
        rst_b = 1'b1;
        pd_req = 1'b1;
        step(12);
        chk(10'({ew_en, ew_ex, mode}), 10'h000);
        pd_req = 1'b0;
        step(12);
        chk(10'({ew_en, ew_ex, mode}), 10'h000);
    endtask
    initial begin
        step(2);
        rst_b = 1'b1;
        step(4);
        t_sync;
        t_async;
        t_exit;
        t_refresh;
        t_short;
        t_dll_on;
        close_out;
    end
    // Run needs well under 500 cycles
    initial begin
        #20000;
        num_errors++;
        close_out;
    end
endmodule
